/* File: hdl/mcxu_top.sv */
// Command and exception unit of the multichannel serial controller
// Functional notes
// [RULE_01] Stop-transmit (001) disables channel and clears its tx_go_bit.
// [RULE_02] Stop-transmit mid-frame sends abort 7F, then idle or flag fill.
// [RULE_03] Stop-transmit between frames keeps sending idle or flag per idle_fill_select.
// [RULE_04] Stop-transmit does not advance the transmit descriptor pointer.
// [RULE_05] Host sets tx_go_bit to start or resume transmission.
// [RULE_06] Host initializes transmit state before restarting a deactivated channel.
// [RULE_07] Host deactivates a channel by clearing slot valid and channel_on_bit.
// [RULE_08] Stop-receive (000) stops reception; receive parameters stay untouched.
// [RULE_09] Host reloads receive state before resuming reception.
// [RULE_10] No start commands; general_mode_register enables transmit and receive.
// [RULE_11] Unmasked exception written at write pointer, valid set, pointer advances or wraps.
// [RULE_12] Queue entry holds channel number and exception flags.
// [RULE_13] Exceptions masked by queue_entry_mask are not queued.
// [RULE_14] Event register updated after queue write; interrupt only if unmasked.
// [RULE_15] queue_event_flag set whenever a new queue entry is added.
// [RULE_16] Host clears queue_event_flag, then drains entries until valid is zero.
// [RULE_17] Host clears all flags of each processed entry.
// [RULE_18] Underrun: abort ones in all slots, flag, stop reading, then idle fill.
// [RULE_19] Host recovers underrun by readying descriptors and setting tx_go_bit.
// [RULE_20] Overrun: mark receivers stopped (bit 20), flag, stop writing buffers.
// [RULE_21] Host recovers overrun by rewriting receive states in order.
// [RULE_22] Host restarts transmit and receive per channel after global errors.
// [RULE_23] Event flags clear on writing one; writing zero leaves them.
// [RULE_24] Queue write into a still valid entry sets overflow flag; exception lost.
// [RULE_25] Command word carries opcode, channel number and a pending flag.
`timescale 1ns/1ps
`include "mcxu_defines.svh"
module mcxu_top #(
  parameter int          NCH          = 32,
  parameter int          CHW          = 5,
  parameter int          QAW          = 4,
  parameter int          FLW          = 8,
  parameter logic [15:0] ABORT_VISITS = `MCXU_ABORT_VISITS
) (
  // Clock and reset
  input  wire logic           core_clk_in,
  input  wire logic           rst_in,
  // Register port
  input  wire logic [7:0]     reg_addr_in,
  input  wire logic [31:0]    reg_wdata_in,
  input  wire logic           reg_wr_in,
  input  wire logic           reg_rd_in,
  output logic      [31:0]    reg_rdata_out,
  // Channel exceptions
  input  wire logic           exc_valid_in,
  input  wire logic [CHW-1:0] exc_channel_in,
  input  wire logic [FLW-1:0] exc_flags_in,
  output logic                exc_ready_out,
  // Transmit slots
  input  wire logic           tx_slot_in,
  input  wire logic [CHW-1:0] tx_slot_channel_in,
  input  wire logic [7:0]     tx_buf_data_in,
  input  wire logic [NCH-1:0] tx_mid_frame_in,
  input  wire logic           tx_underrun_in,
  output logic                tx_byte_valid_out,
  output logic      [7:0]     tx_byte_out,
  output logic                tx_buf_read_out,
  // Receive slots
  input  wire logic           rx_slot_in,
  input  wire logic [CHW-1:0] rx_slot_channel_in,
  input  wire logic [7:0]     rx_data_in,
  input  wire logic           rx_overrun_in,
  output logic                rx_wr_valid_out,
  output logic      [CHW-1:0] rx_wr_channel_out,
  output logic      [7:0]     rx_wr_data_out,
  // Host interrupt
  output logic                host_irq_out
);
  localparam int QD = 1 << QAW;

  logic [15:0]     cmd_r, cmd_nxt;
  logic [3:0]      evt_r, evt_nxt, evmask_r, evmask_nxt;
  logic [FLW-1:0]  qmask_r, qmask_nxt;
  logic [QAW-1:0]  qbase_r, qbase_nxt, qptr_r, qptr_nxt, qlast_r, qlast_nxt;
  logic [NCH-1:0]  txgo_r, txgo_nxt, idlesel_r, idlesel_nxt, chon_r, chon_nxt;
  logic [NCH-1:0]  rxstop_r, rxstop_nxt, abpend_r, abpend_nxt;
  logic [QD-1:0]   qvalid_r, qvalid_nxt;
  logic [1:0]      gmr_r, gmr_nxt;
  logic [15:0]     abcnt_r, abcnt_nxt;
  mcxu_pkg::mcxu_txg_e txg_r, txg_nxt;
  logic [31:0]     rd_r, rd_nxt;
  logic            qsel_r, qsel_nxt;
  logic            txv_r, txv_nxt, txrd_r, txrd_nxt, rxv_r, rxv_nxt;
  logic [7:0]      txb_r, txb_nxt, rxd_r, rxd_nxt;
  logic [CHW-1:0]  rxch_r, rxch_nxt;

  logic            qwin, cmd_exec, accept, q_in, mem_we;
  logic [2:0]      cmd_opc;
  logic [CHW-1:0]  cmd_ch;
  logic [QAW-1:0]  mem_wa;
  logic [15:0]     mem_wd, mem_q;

  assign qwin     = (reg_addr_in[7:6] == `MCXU_QWIN_TAG);
  assign cmd_opc  = cmd_r[`MCXU_CMD_OPC_LSB +: 3]; // RULE_25
  assign cmd_ch   = cmd_r[`MCXU_CMD_CH_LSB +: CHW];
  assign cmd_exec = cmd_r[`MCXU_CMD_PEND_BIT];
  // Host window writes own the memory port for that cycle
  assign exc_ready_out = !(reg_wr_in && qwin);
  assign accept   = exc_valid_in && exc_ready_out;
  assign q_in     = accept && |(exc_flags_in & qmask_r); // RULE_13
  assign mem_we   = (reg_wr_in && qwin) || (q_in && !qvalid_r[qptr_r]);
  assign mem_wa   = (reg_wr_in && qwin) ? reg_addr_in[5:2] : qptr_r;
  // Entry: valid, wrap, spare, channel, flags
  assign mem_wd   = (reg_wr_in && qwin) ? reg_wdata_in[15:0] :
                    {1'b1, (qptr_r == qlast_r), 1'b0, exc_channel_in, exc_flags_in}; // RULE_12

  mcxu_queue_mem #(
    .W  (16),
    .AW (QAW)
  ) u_qmem (
    .core_clk_in (core_clk_in),
    .wr_en_in    (mem_we),
    .wr_addr_in  (mem_wa),
    .wr_data_in  (mem_wd),
    .rd_addr_in  (reg_addr_in[5:2]),
    .rd_data_out (mem_q)
  );

  always_comb begin
    cmd_nxt     = cmd_r;
    evt_nxt     = evt_r;
    evmask_nxt  = evmask_r;
    qmask_nxt   = qmask_r;
    qbase_nxt   = qbase_r;
    qptr_nxt    = qptr_r;
    qlast_nxt   = qlast_r;
    txgo_nxt    = txgo_r;
    idlesel_nxt = idlesel_r;
    chon_nxt    = chon_r;
    rxstop_nxt  = rxstop_r;
    abpend_nxt  = abpend_r;
    qvalid_nxt  = qvalid_r;
    gmr_nxt     = gmr_r;
    abcnt_nxt   = abcnt_r;
    txg_nxt     = txg_r;
    rd_nxt      = `MCXU_RST_WORD;
    qsel_nxt    = reg_rd_in && qwin;
    txv_nxt     = 1'b0;
    txrd_nxt    = 1'b0;
    txb_nxt     = txb_r;
    rxv_nxt     = 1'b0;
    rxd_nxt     = rxd_r;
    rxch_nxt    = rxch_r;
    // Register writes
    if (reg_wr_in) begin
      if (qwin) begin
        qvalid_nxt[reg_addr_in[5:2]] = reg_wdata_in[`MCXU_QE_VALID];
      end
      unique case (reg_addr_in)
        `MCXU_OFF_CMD: begin
          // A new command is refused while one is still pending
          if (!cmd_exec) cmd_nxt = reg_wdata_in[15:0]; // RULE_25
        end
        `MCXU_OFF_EVENT:   evt_nxt = evt_r & ~reg_wdata_in[3:0]; // RULE_23
        `MCXU_OFF_EVMASK:  evmask_nxt = reg_wdata_in[3:0];
        `MCXU_OFF_QMASK:   qmask_nxt = reg_wdata_in[FLW-1:0];
        `MCXU_OFF_QBASE:   qbase_nxt = reg_wdata_in[QAW-1:0];
        `MCXU_OFF_QPTR:    qptr_nxt = reg_wdata_in[QAW-1:0];
        `MCXU_OFF_QLAST:   qlast_nxt = reg_wdata_in[QAW-1:0];
        `MCXU_OFF_TXGO:    txgo_nxt = reg_wdata_in[NCH-1:0]; // RULE_05
        `MCXU_OFF_IDLESEL: idlesel_nxt = reg_wdata_in[NCH-1:0];
        `MCXU_OFF_CHON:    chon_nxt = reg_wdata_in[NCH-1:0]; // RULE_07
        `MCXU_OFF_GMR:     gmr_nxt = reg_wdata_in[1:0]; // RULE_10
        `MCXU_OFF_RXSTOP:  rxstop_nxt = rxstop_r & ~reg_wdata_in[NCH-1:0]; // RULE_21
        default: ;
      endcase
    end
    // Register reads
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `MCXU_OFF_CMD:     rd_nxt[15:0] = cmd_r;
        `MCXU_OFF_EVENT:   rd_nxt[3:0] = evt_r;
        `MCXU_OFF_EVMASK:  rd_nxt[3:0] = evmask_r;
        `MCXU_OFF_QMASK:   rd_nxt[FLW-1:0] = qmask_r;
        `MCXU_OFF_QBASE:   rd_nxt[QAW-1:0] = qbase_r;
        `MCXU_OFF_QPTR:    rd_nxt[QAW-1:0] = qptr_r;
        `MCXU_OFF_QLAST:   rd_nxt[QAW-1:0] = qlast_r;
        `MCXU_OFF_TXGO:    rd_nxt[NCH-1:0] = txgo_r;
        `MCXU_OFF_IDLESEL: rd_nxt[NCH-1:0] = idlesel_r;
        `MCXU_OFF_CHON:    rd_nxt[NCH-1:0] = chon_r;
        `MCXU_OFF_GMR:     rd_nxt[1:0] = gmr_r;
        `MCXU_OFF_RXSTOP:  rd_nxt[NCH-1:0] = rxstop_r;
        `MCXU_OFF_RXSTATE: rd_nxt[`MCXU_RXST_STOP] = rxstop_r[cmd_ch]; // RULE_20
        default: ;
      endcase
    end
    // Command execution, one cycle after the write
    if (cmd_exec) begin
      cmd_nxt[`MCXU_CMD_PEND_BIT] = 1'b0;
      if (cmd_opc == mcxu_pkg::MCXU_OP_STOP_TX) begin
        txgo_nxt[cmd_ch] = 1'b0; // RULE_01
        if (tx_mid_frame_in[cmd_ch]) abpend_nxt[cmd_ch] = 1'b1; // RULE_02
      end else if (cmd_opc == mcxu_pkg::MCXU_OP_STOP_RX) begin
        rxstop_nxt[cmd_ch] = 1'b1; // RULE_08
      end
    end
    // Exception queue; other opcodes carry no meaning and are dropped
    if (q_in) begin
      if (qvalid_r[qptr_r]) begin
        evt_nxt[`MCXU_EV_QUEUE_OVERFLOW_FLAG] = 1'b1; // RULE_24
      end else begin
        qvalid_nxt[qptr_r] = 1'b1; // RULE_11
        qptr_nxt = (qptr_r == qlast_r) ? qbase_r : qptr_r + 1'b1; // RULE_11
        evt_nxt[`MCXU_EV_QUEUE_EVENT_FLAG] = 1'b1; // RULE_15
      end
    end
    // Transmit slot service
    if (tx_slot_in) begin
      txv_nxt = 1'b1;
      if (txg_r == mcxu_pkg::MCXU_TXG_ABORT) begin
        txb_nxt = `MCXU_IDLE_BYTE; // RULE_18
        abcnt_nxt = abcnt_r - 16'h0001;
        if (abcnt_r == 16'h0001) txg_nxt = mcxu_pkg::MCXU_TXG_RUN;
      end else if (abpend_r[tx_slot_channel_in]) begin
        txb_nxt = `MCXU_ABORT_BYTE; // RULE_02
        abpend_nxt[tx_slot_channel_in] = 1'b0;
      end else if (gmr_r[`MCXU_GMR_TXEN] && txgo_r[tx_slot_channel_in] &&
                   chon_r[tx_slot_channel_in]) begin
        txb_nxt = tx_buf_data_in;
        txrd_nxt = 1'b1; // RULE_04
      end else begin
        txb_nxt = idlesel_r[tx_slot_channel_in] ? `MCXU_FLAG_BYTE : `MCXU_IDLE_BYTE; // RULE_03
      end
    end
    // Global underrun wins over go bits, pending aborts and buffer reads; a slot in the same cycle still sends its byte
    if (tx_underrun_in) begin
      txg_nxt = mcxu_pkg::MCXU_TXG_ABORT; // RULE_18
      abcnt_nxt = ABORT_VISITS;
      txgo_nxt = '0;
      abpend_nxt = '0;
      txrd_nxt = 1'b0; // RULE_18
      evt_nxt[`MCXU_EV_GUN] = 1'b1; // RULE_18
    end
    // Receive slot service
    if (rx_slot_in) begin
      rxv_nxt = gmr_r[`MCXU_GMR_RXEN] && !rxstop_r[rx_slot_channel_in]; // RULE_08
      rxd_nxt = rx_data_in;
      rxch_nxt = rx_slot_channel_in;
    end
    if (rx_overrun_in) begin
      rxstop_nxt = '1; // RULE_20
      rxv_nxt = 1'b0;
      evt_nxt[`MCXU_EV_GOV] = 1'b1; // RULE_20
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cmd_r <= '0; evt_r <= '0; evmask_r <= '0; qmask_r <= '0;
      qbase_r <= '0; qptr_r <= '0; qlast_r <= '1; txgo_r <= '0;
      idlesel_r <= '0; chon_r <= '0; rxstop_r <= '0; abpend_r <= '0;
      qvalid_r <= '0; gmr_r <= '0; abcnt_r <= '0;
      txg_r <= mcxu_pkg::MCXU_TXG_RUN;
      rd_r <= '0; qsel_r <= 1'b0; txv_r <= 1'b0; txrd_r <= 1'b0;
      txb_r <= '0; rxv_r <= 1'b0; rxd_r <= '0; rxch_r <= '0;
    end else begin
      cmd_r <= cmd_nxt; evt_r <= evt_nxt; evmask_r <= evmask_nxt;
      qmask_r <= qmask_nxt; qbase_r <= qbase_nxt; qptr_r <= qptr_nxt;
      qlast_r <= qlast_nxt; txgo_r <= txgo_nxt; idlesel_r <= idlesel_nxt;
      chon_r <= chon_nxt; rxstop_r <= rxstop_nxt; abpend_r <= abpend_nxt;
      qvalid_r <= qvalid_nxt; gmr_r <= gmr_nxt; abcnt_r <= abcnt_nxt;
      txg_r <= txg_nxt; rd_r <= rd_nxt; qsel_r <= qsel_nxt;
      txv_r <= txv_nxt; txrd_r <= txrd_nxt; txb_r <= txb_nxt;
      rxv_r <= rxv_nxt; rxd_r <= rxd_nxt; rxch_r <= rxch_nxt;
    end
  end

  assign reg_rdata_out     = qsel_r ? {16'h0000, mem_q} : rd_r;
  assign tx_byte_valid_out = txv_r;
  assign tx_byte_out       = txb_r;
  assign tx_buf_read_out   = txrd_r;
  assign rx_wr_valid_out   = rxv_r;
  assign rx_wr_channel_out = rxch_r;
  assign rx_wr_data_out    = rxd_r;
  assign host_irq_out      = |(evt_r & evmask_r); // RULE_14

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  stop_tx_go_a: assert property ( // RULE_01
    (cmd_exec && cmd_opc == mcxu_pkg::MCXU_OP_STOP_TX && !(reg_wr_in &&
      reg_addr_in == `MCXU_OFF_TXGO)) |=> !txgo_r[$past(cmd_ch)])
    else $error("stop transmit left go bit set");

  abort_byte_a: assert property ( // RULE_02
    (tx_slot_in && txg_r == mcxu_pkg::MCXU_TXG_RUN && !tx_underrun_in &&
     abpend_r[tx_slot_channel_in]) |=> (tx_byte_out == `MCXU_ABORT_BYTE) && !tx_buf_read_out)
    else $error("abort byte not sent");

  idle_fill_a: assert property ( // RULE_03
    (tx_slot_in && txg_r == mcxu_pkg::MCXU_TXG_RUN && !abpend_r[tx_slot_channel_in] &&
     !txgo_r[tx_slot_channel_in])
    |=> tx_byte_out == ($past(idlesel_r[tx_slot_channel_in]) ? `MCXU_FLAG_BYTE
                                                             : `MCXU_IDLE_BYTE))
    else $error("wrong fill byte");

  no_advance_a: assert property ( // RULE_04
    (tx_slot_in && !txgo_r[tx_slot_channel_in]) |=> !tx_buf_read_out)
    else $error("buffer read on stopped channel");

  stop_rx_a: assert property ( // RULE_08
    (cmd_exec && cmd_opc == mcxu_pkg::MCXU_OP_STOP_RX) |=> rxstop_r[$past(cmd_ch)])
    else $error("stop receive not held");

  rx_held_a: assert property ( // RULE_08
    (rx_slot_in && rxstop_r[rx_slot_channel_in]) |=> !rx_wr_valid_out)
    else $error("stopped channel still written");

  gmr_gate_a: assert property ( // RULE_10
    (tx_slot_in && !gmr_r[`MCXU_GMR_TXEN]) |=> !tx_buf_read_out)
    else $error("transmit read while disabled");

  queue_wr_a: assert property ( // RULE_11
    (q_in && !qvalid_r[qptr_r] && !tx_underrun_in && !rx_overrun_in &&
     !(reg_wr_in && reg_addr_in == `MCXU_OFF_QPTR))
    |=> qvalid_r[$past(qptr_r)] && evt_r[`MCXU_EV_QUEUE_EVENT_FLAG] &&
        qptr_r == ($past(qptr_r == qlast_r) ? $past(qbase_r) : $past(qptr_r) + 1'b1))
    else $error("queue entry not written");

  queue_mask_a: assert property ( // RULE_13
    (accept && !q_in && !(reg_wr_in && reg_addr_in == `MCXU_OFF_QPTR)) |=> $stable(qptr_r))
    else $error("masked exception queued");

  sequence irq_cause_s;
    q_in && !qvalid_r[qptr_r] && evmask_r[`MCXU_EV_QUEUE_EVENT_FLAG] &&
      !(reg_wr_in && reg_addr_in == `MCXU_OFF_EVMASK);
  endsequence
  irq_raise_a: assert property (irq_cause_s |=> host_irq_out) // RULE_14
    else $error("interrupt not raised");

  sequence urun_s;
    tx_underrun_in;
  endsequence
  sequence urun_effect_s;
    txg_r == mcxu_pkg::MCXU_TXG_ABORT && evt_r[`MCXU_EV_GUN] && txgo_r == '0;
  endsequence
  underrun_a: assert property (urun_s |=> urun_effect_s ##0 !tx_buf_read_out) // RULE_18
    else $error("underrun recovery not entered");

  overrun_a: assert property ( // RULE_20
    rx_overrun_in |=> (&rxstop_r) && evt_r[`MCXU_EV_GOV] && !rx_wr_valid_out)
    else $error("overrun did not stop receivers");

  event_clear_a: assert property ( // RULE_23
    (reg_wr_in && reg_addr_in == `MCXU_OFF_EVENT && !q_in && !tx_underrun_in &&
     !rx_overrun_in) |=> evt_r == ($past(evt_r) & ~$past(reg_wdata_in[3:0])))
    else $error("event write one did not clear");

  overflow_a: assert property ( // RULE_24
    (q_in && qvalid_r[qptr_r] && !(reg_wr_in && reg_addr_in == `MCXU_OFF_QPTR))
    |=> evt_r[`MCXU_EV_QUEUE_OVERFLOW_FLAG] && $stable(qptr_r))
    else $error("overflow not flagged");
endmodule // mcxu_top

/* File: pkg/mcxu_defines.svh */
// Register offsets, field positions, reset values and counts of the exception unit
`ifndef MCXU_DEFINES_SVH
`define MCXU_DEFINES_SVH
`define MCXU_OFF_CMD        8'h00
`define MCXU_OFF_EVENT      8'h04
`define MCXU_OFF_EVMASK     8'h08
`define MCXU_OFF_QMASK      8'h0C
`define MCXU_OFF_QBASE      8'h10
`define MCXU_OFF_QPTR       8'h14
`define MCXU_OFF_QLAST      8'h18
`define MCXU_OFF_TXGO       8'h20
`define MCXU_OFF_IDLESEL    8'h24
`define MCXU_OFF_CHON       8'h28
`define MCXU_OFF_GMR        8'h2C
`define MCXU_OFF_RXSTOP     8'h30
`define MCXU_OFF_RXSTATE    8'h34
`define MCXU_QWIN_TAG       2'h1
`define MCXU_CMD_OPC_LSB    12
`define MCXU_CMD_CH_LSB     6
`define MCXU_CMD_PEND_BIT   0
`define MCXU_EV_GOV         0
`define MCXU_EV_GUN         1
`define MCXU_EV_QUEUE_EVENT_FLAG        2
`define MCXU_EV_QUEUE_OVERFLOW_FLAG        3
`define MCXU_GMR_TXEN       0
`define MCXU_GMR_RXEN       1
`define MCXU_QE_VALID       15
`define MCXU_QE_WRAP        14
`define MCXU_RXST_STOP      20
`define MCXU_ABORT_BYTE     8'h7F
`define MCXU_FLAG_BYTE      8'h7E
`define MCXU_IDLE_BYTE      8'hFF
`define MCXU_ABORT_VISITS   16'h0040
`define MCXU_RST_WORD       32'h0000_0000
`endif

/* File: pkg/mcxu_pkg.sv */
// Types shared by the exception unit
package mcxu_pkg;
  typedef enum logic [2:0] {
    MCXU_OP_STOP_RX = 3'h0,
    MCXU_OP_STOP_TX = 3'h1
  } mcxu_opcode_e;
  typedef enum logic [0:0] {
    MCXU_TXG_RUN   = 1'h0,
    MCXU_TXG_ABORT = 1'h1
  } mcxu_txg_e;
endpackage

/* File: hdl/mcxu_queue_mem.sv */
// Exception queue storage with registered read data
`timescale 1ns/1ps
module mcxu_queue_mem #(
  parameter int W   = 16,
  parameter int AW  = 4
) (
  // Clock
  input  wire logic          core_clk_in,
  // Write port
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [W-1:0]  wr_data_in,
  // Read port
  input  wire logic [AW-1:0] rd_addr_in,
  output logic      [W-1:0]  rd_data_out
);
  logic [W-1:0] mem_r [0:(1<<AW)-1];

  always_ff @(posedge core_clk_in) begin
    if (wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_r[rd_addr_in];
  end
endmodule // mcxu_queue_mem

/* File: verification/mcxu_exc_src.sv */
// Exception source model on the far side of the exception handshake
`timescale 1ns/1ps
module mcxu_exc_src (
  // Clock
  input  wire logic       core_clk_in,
  // Exception handshake
  input  wire logic       exc_ready_in,
  output logic            exc_valid_out,
  output logic [4:0]      exc_channel_out,
  output logic [7:0]      exc_flags_out
);
  initial begin
    exc_valid_out   = 1'b0;
    exc_channel_out = 5'h00;
    exc_flags_out   = 8'h00;
  end
  // Held until taken or for at most 50 more cycles; released lines invert so stale data never match
  task automatic offer(input logic [4:0] ch, input logic [7:0] fl, input int stall);
    int n;
    n = 0;
    repeat (stall) @(posedge core_clk_in);
    exc_valid_out   <= 1'b1;
    exc_channel_out <= ch;
    exc_flags_out   <= fl;
    @(posedge core_clk_in);
    while (exc_ready_in !== 1'b1 && n < 50) begin
      n++;
      @(posedge core_clk_in);
    end
    exc_valid_out   <= 1'b0;
    exc_channel_out <= ~ch;
    exc_flags_out   <= ~fl;
  endtask
endmodule // mcxu_exc_src

/* File: verification/tb_top.sv */
// Self-checking bench of the command and exception unit
`timescale 1ns/1ps
`include "mcxu_defines.svh"
module tb_top;
  logic        core_clk_in, rst_in, reg_wr_in, reg_rd_in;
  logic [7:0]  reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, tx_mid_frame_in;
  logic        exc_valid_in, exc_ready_out, tx_slot_in, tx_underrun_in;
  logic [4:0]  exc_channel_in, tx_slot_channel_in, rx_slot_channel_in, rx_wr_channel_out;
  logic [7:0]  exc_flags_in, tx_buf_data_in, tx_byte_out, rx_data_in, rx_wr_data_out, d;
  logic        tx_byte_valid_out, tx_buf_read_out, rx_slot_in, rx_overrun_in;
  logic        rx_wr_valid_out, host_irq_out;
  int          num_errors, n_checks, cyc, seed, mptr, mlast, mmask;
  int          ment[16];

  mcxu_top #(.ABORT_VISITS(16'h0004)) DUT (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .exc_valid_in(exc_valid_in),
    .exc_channel_in(exc_channel_in), .exc_flags_in(exc_flags_in),
    .exc_ready_out(exc_ready_out), .tx_slot_in(tx_slot_in),
    .tx_slot_channel_in(tx_slot_channel_in), .tx_buf_data_in(tx_buf_data_in),
    .tx_mid_frame_in(tx_mid_frame_in), .tx_underrun_in(tx_underrun_in),
    .tx_byte_valid_out(tx_byte_valid_out), .tx_byte_out(tx_byte_out),
    .tx_buf_read_out(tx_buf_read_out), .rx_slot_in(rx_slot_in),
    .rx_slot_channel_in(rx_slot_channel_in), .rx_data_in(rx_data_in),
    .rx_overrun_in(rx_overrun_in), .rx_wr_valid_out(rx_wr_valid_out),
    .rx_wr_channel_out(rx_wr_channel_out), .rx_wr_data_out(rx_wr_data_out),
    .host_irq_out(host_irq_out));
  mcxu_exc_src P (.core_clk_in(core_clk_in), .exc_ready_in(exc_ready_out),
    .exc_valid_out(exc_valid_in), .exc_channel_out(exc_channel_in),
    .exc_flags_out(exc_flags_in));

  always #4 core_clk_in = ~core_clk_in;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Generous ceiling; the sequence needs well under a thousand cycles
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    #1 chk(32'(exc_ready_out), 32'(a[7:6] != 2'h1), "window ready");
    @(posedge core_clk_in);
    reg_wr_in    <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
    @(posedge core_clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in   <= 1'b0;
    #1 chk(reg_rdata_out, exp, msg);
  endtask
  // Command executes one cycle after the write is taken
  task automatic cmd(input logic [2:0] op, input logic [4:0] ch);
    wr(`MCXU_OFF_CMD, (32'(op) << 12) | (32'(ch) << 6) | 32'h1);
    @(posedge core_clk_in);
  endtask
  task automatic slot(input logic [4:0] ch, input logic [7:0] b, input logic [7:0] eb,
                      input logic er);
    @(posedge core_clk_in);
    tx_slot_in         <= 1'b1;
    tx_slot_channel_in <= ch;
    tx_buf_data_in     <= b;
    @(posedge core_clk_in);
    tx_slot_in         <= 1'b0;
    #1 chk({tx_byte_valid_out, tx_buf_read_out, tx_byte_out}, {1'b1, er, eb}, "tx slot");
  endtask
  task automatic rxs(input logic [4:0] ch, input logic ev);
    d = 8'($random(seed));
    @(posedge core_clk_in);
    rx_slot_in         <= 1'b1;
    rx_slot_channel_in <= ch;
    rx_data_in         <= d;
    @(posedge core_clk_in);
    rx_slot_in         <= 1'b0;
    #1 chk(32'(rx_wr_valid_out), 32'(ev), "rx valid");
    if (ev) begin
      chk({rx_wr_channel_out, rx_wr_data_out}, {ch, d}, "rx data");
    end
  endtask
  // Queue model: pointer wraps at the last index, a still valid entry overflows
  task automatic qexc(input logic [4:0] ch, input logic [7:0] fl, output bit ovf);
    ovf = 1'b0;
    P.offer(ch, fl, 1);
    if ((fl & mmask) != 0) begin
      if (ment[mptr] != 0) begin
        ovf = 1'b1;
      end else begin
        ment[mptr] = 32'h8000 | ((mptr == mlast) ? 32'h4000 : 32'h0) | (ch << 8) | fl;
        mptr = (mptr == mlast) ? 0 : mptr + 1;
      end
    end
  endtask
  task automatic qchk();
    for (int i = 0; i <= mlast; i++) begin
      rdc(8'h40 + 8'(4 * i), 32'(ment[i]), "queue entry");
    end
    rdc(`MCXU_OFF_QPTR, 32'(mptr), "queue pointer");
  endtask

  initial begin
    bit ovf;
    core_clk_in = 1'b0;
    rst_in = 1'b1;
    {reg_wr_in, reg_rd_in, tx_slot_in, tx_underrun_in, rx_slot_in, rx_overrun_in} = 6'h00;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0;
    tx_mid_frame_in = 32'h0;
    {tx_slot_channel_in, rx_slot_channel_in, tx_buf_data_in, rx_data_in} = 26'h0;
    seed = 32'h8836;
    mptr = 0;
    mlast = 15;
    mmask = 8'h0F;
    foreach (ment[i]) ment[i] = 0;
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rdc(`MCXU_OFF_QLAST, 32'hF, "last index reset");
    rdc(`MCXU_OFF_EVENT, 32'h0, "event reset");
    wr(8'hFC, 32'hFFFF_FFFF);
    rdc(8'hFC, 32'h0, "unmapped");
    wr(`MCXU_OFF_QMASK, 32'h0F);
    wr(`MCXU_OFF_EVMASK, 32'h4);
    wr(`MCXU_OFF_QLAST, 32'h1);
    mlast = 1;
    qexc(5'h03, 8'hF0, ovf);
    rdc(`MCXU_OFF_EVENT, 32'h0, "masked exception");
    for (int i = 0; i < 2; i++) begin
      qexc(5'($random(seed)), 8'($random(seed)) | 8'h01, ovf);
    end
    qchk();
    rdc(`MCXU_OFF_EVENT, 32'h4, "queue event");
    chk(32'(host_irq_out), 32'h1, "irq unmasked");
    qexc(5'h07, 8'h02, ovf);
    chk(32'(ovf), 32'h1, "model overflow");
    rdc(`MCXU_OFF_EVENT, 32'hC, "overflow flag");
    qchk();
    wr(`MCXU_OFF_EVENT, 32'h0);
    rdc(`MCXU_OFF_EVENT, 32'hC, "write zero keeps");
    wr(`MCXU_OFF_EVENT, 32'h4);
    rdc(`MCXU_OFF_EVENT, 32'h8, "write one clears");
    chk(32'(host_irq_out), 32'h0, "irq cleared");
    wr(8'h40, 32'h0);
    wr(8'h44, 32'h0);
    ment[0] = 0;
    ment[1] = 0;
    wr(`MCXU_OFF_EVMASK, 32'h0);
    qexc(5'h1F, 8'h08, ovf);
    qchk();
    rdc(`MCXU_OFF_EVENT, 32'hC, "event set");
    chk(32'(host_irq_out), 32'h0, "irq masked");
    wr(`MCXU_OFF_GMR, 32'h3);
    wr(`MCXU_OFF_CHON, 32'hFFFF_FFFF);
    wr(`MCXU_OFF_TXGO, 32'h18);
    wr(`MCXU_OFF_IDLESEL, 32'h8);
    d = 8'($random(seed));
    slot(5'h03, d, d, 1'b1);
    tx_mid_frame_in <= 32'h8;
    cmd(mcxu_pkg::MCXU_OP_STOP_TX, 5'h03);
    rdc(`MCXU_OFF_TXGO, 32'h10, "go cleared");
    rdc(`MCXU_OFF_CMD, 32'h0000_10C0, "pending done");
    slot(5'h03, d, `MCXU_ABORT_BYTE, 1'b0);
    slot(5'h03, d, `MCXU_FLAG_BYTE, 1'b0);
    cmd(mcxu_pkg::MCXU_OP_STOP_TX, 5'h04);
    slot(5'h04, d, `MCXU_IDLE_BYTE, 1'b0);
    cmd(3'h2, 5'h03);
    slot(5'h03, d, `MCXU_FLAG_BYTE, 1'b0);
    wr(`MCXU_OFF_TXGO, 32'h8);
    slot(5'h03, d, d, 1'b1);
    wr(`MCXU_OFF_EVENT, 32'hF);
    wr(`MCXU_OFF_EVMASK, 32'h3);
    @(posedge core_clk_in);
    tx_underrun_in <= 1'b1;
    @(posedge core_clk_in);
    tx_underrun_in <= 1'b0;
    repeat (4) slot(5'h03, d, 8'hFF, 1'b0);
    slot(5'h03, d, `MCXU_FLAG_BYTE, 1'b0);
    rdc(`MCXU_OFF_EVENT, 32'h2, "underrun flag");
    chk(32'(host_irq_out), 32'h1, "underrun irq");
    rdc(`MCXU_OFF_TXGO, 32'h0, "go stopped");
    wr(`MCXU_OFF_TXGO, 32'h8);
    slot(5'h03, d, d, 1'b1);
    rxs(5'h02, 1'b1);
    cmd(mcxu_pkg::MCXU_OP_STOP_RX, 5'h02);
    rxs(5'h02, 1'b0);
    rxs(5'h05, 1'b1);
    rdc(`MCXU_OFF_RXSTATE, 32'h0010_0000, "rx stopped view");
    wr(`MCXU_OFF_RXSTOP, 32'h4);
    rxs(5'h02, 1'b1);
    wr(`MCXU_OFF_EVENT, 32'hF);
    @(posedge core_clk_in);
    rx_overrun_in <= 1'b1;
    @(posedge core_clk_in);
    rx_overrun_in <= 1'b0;
    rxs(5'h05, 1'b0);
    rdc(`MCXU_OFF_RXSTATE, 32'h0010_0000, "overrun bit 20");
    rdc(`MCXU_OFF_EVENT, 32'h1, "overrun flag");
    wr(`MCXU_OFF_RXSTOP, 32'hFFFF_FFFF);
    rxs(5'h05, 1'b1);
    wr(`MCXU_OFF_GMR, 32'h1);
    rxs(5'h05, 1'b0);
    slot(5'h03, d, d, 1'b1);
    wr(`MCXU_OFF_CHON, 32'hFFFF_FFF7);
    slot(5'h03, d, `MCXU_FLAG_BYTE, 1'b0);
    complete_run();
  end
endmodule // tb_top
